// ---- src/dio_bank_pkg.sv ----
// shared constants and carrier types for the discrete i/o channel bank
package io_bank_pkg;
   localparam int NUM_CH = 16;
   localparam int WD_W = 16;
   localparam logic [WD_W-1:0] WD_OFF_LO = 16'h0000;
   localparam logic [WD_W-1:0] WD_OFF_HI = 16'hFFFF;
   localparam int LABEL_CHARS = 8;
   localparam int LABEL_W = LABEL_CHARS * 8;
   localparam int CH_IDX_W = 4;
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
   localparam int TICK_W = 27;
   localparam int REFRESH_PERIOD_MS = 100;
   localparam int REFRESH_CYCLES = (CLK_HZ / 1000) * REFRESH_PERIOD_MS;
   localparam int REFRESH_W = 24;

   typedef struct packed {
      logic [WD_W-1:0] wd_timeout;
      logic wd_state_on;
      logic refresh_en;
      logic invert_in;
   } ch_cfg_t;

   typedef struct packed {
      logic valid;
      logic [CH_IDX_W-1:0] ch;
      logic write;
      logic value;
   } ch_access_t;
endpackage

// ---- src/label_store.sv ----
// small memory holding the informational per-channel labels
module label_store
   import io_bank_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic wr_en_in,
   input wire logic [CH_IDX_W-1:0] wr_ch_in,
   input wire logic [LABEL_W-1:0] wr_data_in,
   input wire logic [CH_IDX_W-1:0] rd_ch_in,
   output logic [LABEL_W-1:0] rd_data_out
);
   logic [LABEL_W-1:0] mem [NUM_CH];

   always_ff @(posedge clk_sys_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_ch_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rd_data_out <= '0;
      end
      else
      begin
         rd_data_out <= mem[rd_ch_in];
      end
   end
endmodule

// ---- src/discrete_io_channel_bank.sv ----
// sixteen-channel open-drain i/o bank with per-channel watchdog, refresh and input inversion
// Function
// RULE1 - sixteen channels, each with its own watchdog, fallback, refresh, inversion settings
// RULE2 - watchdog timeout values 1 to 65534 seconds are enabled periods
// RULE3 - timeout 0 or 65535 disables the channel watchdog completely
// RULE4 - no read or write for full period causes timeout; access restarts period
// RULE5 - on timeout the output goes to the configured fallback on or off
// RULE6 - refresh enabled: output periodically rewritten with programmed value
// RULE7 - inputs active-low; inversion option inverts reported input value
// RULE8 - inversion applies to fieldbus input and messaging path input alike
// RULE9 - output writes ignore inversion; writing 1 turns output on
// RULE10 - input samples drain node, giving readback of the output
// RULE11 - to monitor field signals, master first switches that output off
// RULE12 - local test writes accepted only with no network i/o connection
// RULE13 - eight-character label per channel, informational only
// RULE14 - watchdogs count one-second ticks; everything resets to disabled
module discrete_io_channel_bank
   import io_bank_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic cfg_wr_in,
   input wire logic [CH_IDX_W-1:0] cfg_ch_in,
   input wire io_bank_pkg::ch_cfg_t cfg_data_in,
   input wire logic [LABEL_W-1:0] cfg_label_in,
   input wire logic [CH_IDX_W-1:0] label_rd_ch_in,
   input wire io_bank_pkg::ch_access_t net_access_in,
   input wire io_bank_pkg::ch_access_t test_access_in,
   input wire logic net_conn_active_in,
   input wire logic [NUM_CH-1:0] drain_n_in,
   output logic [NUM_CH-1:0] drive_on_out,
   output logic [NUM_CH-1:0] input_value_out,
   output logic [NUM_CH-1:0] msg_input_out,
   output logic [NUM_CH-1:0] wd_expired_out,
   output logic [NUM_CH-1:0] refresh_pulse_out,
   output logic test_reject_out,
   output logic [LABEL_W-1:0] label_out
);
   import io_bank_pkg::*;

   ch_cfg_t cfg [NUM_CH];
   logic [NUM_CH-1:0] prog_value;
   logic [WD_W-1:0] wd_count [NUM_CH];
   logic [TICK_W-1:0] tick_div;
   logic sec_tick;
   logic [REFRESH_W-1:0] refresh_div;
   logic refresh_tick;
   logic test_ok;
   logic [NUM_CH-1:0] access_hit;
   logic [NUM_CH-1:0] write_hit;
   logic [NUM_CH-1:0] write_val;

   // local test writes may only pass with no live network session
   assign test_ok = test_access_in.valid && !net_conn_active_in; // [RULE12]

   // one-second tick for all watchdogs
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         tick_div <= '0;
         sec_tick <= 1'b0;
      end
      else if (tick_div == TICK_W'(TICK_CYCLES - 1))
      begin
         tick_div <= '0;
         sec_tick <= 1'b1; // [RULE14]
      end
      else
      begin
         tick_div <= tick_div + 1'b1;
         sec_tick <= 1'b0;
      end
   end

   // refresh period is short so a latched shutdown recovers quickly
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         refresh_div <= '0;
         refresh_tick <= 1'b0;
      end
      else if (refresh_div == REFRESH_W'(REFRESH_CYCLES - 1))
      begin
         refresh_div <= '0;
         refresh_tick <= 1'b1;
      end
      else
      begin
         refresh_div <= refresh_div + 1'b1;
         refresh_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         test_reject_out <= 1'b0;
      end
      else
      begin
         test_reject_out <= test_access_in.valid && test_access_in.write && net_conn_active_in; // [RULE12]
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         logic wd_enabled;
         logic net_hit;
         logic tst_hit;
         logic rd_in;

         assign net_hit = net_access_in.valid && (net_access_in.ch == CH_IDX_W'(g));
         assign tst_hit = test_ok && (test_access_in.ch == CH_IDX_W'(g));
         assign access_hit[g] = net_hit || tst_hit; // [RULE4]
         assign write_hit[g] = (net_hit && net_access_in.write) || (tst_hit && test_access_in.write);
         // network write wins if both arrive together
         assign write_val[g] = net_hit && net_access_in.write ? net_access_in.value : test_access_in.value;
         assign wd_enabled = (cfg[g].wd_timeout != WD_OFF_LO) && (cfg[g].wd_timeout != WD_OFF_HI); // [RULE2] [RULE3]
         // drain low means input active; the readback sees the real node
         assign rd_in = ~drain_n_in[g] ^ cfg[g].invert_in; // [RULE7] [RULE10]

         always_ff @(posedge clk_sys_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               cfg[g] <= '0; // [RULE14]
            end
            else if (cfg_wr_in && cfg_ch_in == CH_IDX_W'(g))
            begin
               cfg[g] <= cfg_data_in; // [RULE1]
            end
         end

         // a timeout falls back to the chosen state; a later write overrides it
         always_ff @(posedge clk_sys_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               prog_value[g] <= 1'b0;
            end
            else if (write_hit[g])
            begin
               prog_value[g] <= write_val[g]; // [RULE9]
            end
            // a same-cycle access restarts the period, so no fallback is applied then
            else if (wd_enabled && sec_tick && !access_hit[g] && !wd_expired_out[g]
               && wd_count[g] == cfg[g].wd_timeout - 1'b1)
            begin
               prog_value[g] <= cfg[g].wd_state_on; // [RULE5]
            end
         end

         always_ff @(posedge clk_sys_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               wd_count[g] <= '0;
               wd_expired_out[g] <= 1'b0;
            end
            else if (!wd_enabled || access_hit[g])
            begin
               wd_count[g] <= '0; // [RULE3] [RULE4]
               wd_expired_out[g] <= 1'b0;
            end
            else if (sec_tick && !wd_expired_out[g])
            begin
               if (wd_count[g] == cfg[g].wd_timeout - 1'b1)
               begin
                  wd_expired_out[g] <= 1'b1; // [RULE4]
               end
               else
               begin
                  wd_count[g] <= wd_count[g] + 1'b1;
               end
            end
         end

         always_ff @(posedge clk_sys_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               drive_on_out[g] <= 1'b0;
               refresh_pulse_out[g] <= 1'b0;
            end
            else
            begin
               drive_on_out[g] <= prog_value[g];
               refresh_pulse_out[g] <= refresh_tick && cfg[g].refresh_en; // [RULE6]
            end
         end

         always_ff @(posedge clk_sys_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               input_value_out[g] <= 1'b0;
               msg_input_out[g] <= 1'b0;
            end
            else
            begin
               input_value_out[g] <= rd_in; // [RULE8]
               msg_input_out[g] <= rd_in; // [RULE8]
            end
         end
      end
   endgenerate

   // labels are stored and read back only; nothing else looks at them
   label_store u_labels ( // [RULE13]
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .wr_en_in(cfg_wr_in),
      .wr_ch_in(cfg_ch_in),
      .wr_data_in(cfg_label_in),
      .rd_ch_in(label_rd_ch_in),
      .rd_data_out(label_out)
   );
endmodule

// ---- verif/dio_bank_props.sv ----
// port-level assertions for the discrete i/o channel bank
module io_bank_props
   import io_bank_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire io_bank_pkg::ch_access_t net_access_in,
   input wire io_bank_pkg::ch_access_t test_access_in,
   input wire logic net_conn_active_in,
   input wire logic [NUM_CH-1:0] drive_on_out,
   input wire logic [NUM_CH-1:0] input_value_out,
   input wire logic [NUM_CH-1:0] msg_input_out,
   input wire logic [NUM_CH-1:0] wd_expired_out,
   input wire logic test_reject_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   sequence net_wr;
      net_access_in.valid && net_access_in.write;
   endsequence
   sequence test_wr;
      test_access_in.valid && test_access_in.write;
   endsequence
   a_net_write_drive: assert property (net_wr |-> ##2
      drive_on_out[$past(net_access_in.ch, 2)] == $past(net_access_in.value, 2)) else $error("net write lost");
   a_test_write_drive: assert property (test_wr ##0 (!net_conn_active_in && !net_access_in.valid) |-> ##2
      drive_on_out[$past(test_access_in.ch, 2)] == $past(test_access_in.value, 2)) else $error("test write lost");
   a_test_refused: assert property (test_wr ##0 net_conn_active_in |=> test_reject_out)
      else $error("refusal not flagged");
   a_reject_cause: assert property (test_reject_out |-> $past(net_conn_active_in && test_access_in.valid))
      else $error("spurious refusal");
   a_msg_matches: assert property (msg_input_out == input_value_out)
      else $error("message input differs");
   a_reset_zero: assert property ($rose(resetn_in) |-> drive_on_out == '0 && wd_expired_out == '0)
      else $error("outputs not cleared by reset");
   a_drive_cause: assert property ($changed(drive_on_out) |-> $past(net_access_in.valid, 2)
      || $past(test_access_in.valid, 2) || $past(|wd_expired_out)) else $error("drive changed unprompted");
   a_access_clears: assert property (net_access_in.valid |=>
      !wd_expired_out[$past(net_access_in.ch)]) else $error("expiry not cleared by access");
endmodule

bind discrete_io_channel_bank io_bank_props i_props (.clk_sys_in, .resetn_in, .net_access_in, .test_access_in,
   .net_conn_active_in, .drive_on_out, .input_value_out, .msg_input_out, .wd_expired_out, .test_reject_out);

// ---- verif/field_wiring.sv ----
// field side model: pulled-up drains sunk by the low-side switch or a field contact
module field_wiring
   import io_bank_pkg::*;
(
   input wire logic [NUM_CH-1:0] drive_on_in,
   input wire logic [NUM_CH-1:0] field_low_in,
   output logic [NUM_CH-1:0] drain_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-up wins unless something sinks the node, so the input reads the drain back
   assign drain_n_out = ~(drive_on_in | field_low_in);
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the discrete i/o channel bank
module tb
   import io_bank_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 0;
   logic resetn_in = 0;
   logic cfg_wr_in = 0;
   logic [CH_IDX_W-1:0] cfg_ch_in = '0;
   logic [CH_IDX_W-1:0] label_rd_ch_in = '0;
   ch_cfg_t cfg_data_in = '0;
   logic [LABEL_W-1:0] cfg_label_in = '0;
   ch_access_t net_access_in = '0;
   ch_access_t test_access_in = '0;
   logic net_conn_active_in = 0;
   logic [NUM_CH-1:0] field = '0;
   logic [NUM_CH-1:0] drain_n_in, drive_on_out, input_value_out, msg_input_out, wd_expired_out, refresh_pulse_out;
   logic test_reject_out;
   logic [LABEL_W-1:0] label_out;
   logic [LABEL_W-1:0] labels [NUM_CH];
   logic [NUM_CH-1:0] exp_drv = '0;
   logic [NUM_CH-1:0] inv = '0;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;

   always #4 clk_sys_in = ~clk_sys_in;

   discrete_io_channel_bank i_dut (.clk_sys_in, .resetn_in, .cfg_wr_in, .cfg_ch_in, .cfg_data_in, .cfg_label_in,
      .label_rd_ch_in, .net_access_in, .test_access_in, .net_conn_active_in, .drain_n_in, .drive_on_out,
      .input_value_out, .msg_input_out, .wd_expired_out, .refresh_pulse_out, .test_reject_out, .label_out);
   field_wiring i_field (.drive_on_in(drive_on_out), .field_low_in(field), .drain_n_out(drain_n_in));

   task chk(input logic [LABEL_W-1:0] got, input logic [LABEL_W-1:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task summarize;
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // the run needs about 300 cycles; anything far past that is a hang
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         summarize();
      end
   end

   initial
   begin
      ch_access_t n, t;
      logic cn, rej;
      logic [NUM_CH-1:0] f;
      void'($urandom(94339));
      repeat (10) @(posedge clk_sys_in);
      resetn_in <= 1;
      @(posedge clk_sys_in);
      #1 chk(drive_on_out, 0);
      for (int c = 0; c < NUM_CH; c++)
      begin
         @(posedge clk_sys_in);
         inv[c] = $urandom_range(0, 1);
         labels[c] = {$urandom, $urandom};
         cfg_wr_in <= 1;
         cfg_ch_in <= c[CH_IDX_W-1:0];
         cfg_data_in <= '{c[0] ? WD_OFF_HI : WD_OFF_LO, 1'b1, 1'($urandom), inv[c]};
         cfg_label_in <= labels[c];
      end
      @(posedge clk_sys_in) cfg_wr_in <= 0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         @(posedge clk_sys_in) label_rd_ch_in <= c[CH_IDX_W-1:0];
         @(posedge clk_sys_in) #1 chk(label_out, labels[c]);
      end
      repeat (60)
      begin
         @(posedge clk_sys_in);
         n = 7'($urandom);
         t = 7'($urandom);
         cn = $urandom_range(0, 1);
         // both writes may land on the same channel; there the network write wins
         if (t.valid && t.write && !cn)
            exp_drv[t.ch] = t.value;
         if (n.valid && n.write)
            exp_drv[n.ch] = n.value;
         rej = t.valid && t.write && cn;
         f = 16'($urandom) & ~exp_drv;
         net_access_in <= n;
         test_access_in <= t;
         net_conn_active_in <= cn;
         field <= f;
         @(posedge clk_sys_in);
         net_access_in <= '0;
         test_access_in <= '0;
         #1 chk(test_reject_out, rej);
         @(posedge clk_sys_in) #1 chk(drive_on_out, exp_drv);
         @(posedge clk_sys_in) #1 chk(input_value_out, (exp_drv | f) ^ inv);
         chk(msg_input_out, (exp_drv | f) ^ inv);
         chk(wd_expired_out, 0);
         chk(refresh_pulse_out, 0);
      end
      summarize();
   end
endmodule
